// ==== verilog/health_pkg.sv ====
// health-monitoring command handler: task-file layouts, opcodes, codes
// assumes one device clock; no timing constants are needed
package health_pkg;
  typedef struct packed {
    logic [7:0] feature;
    logic [7:0] count;
    logic [7:0] lba_low;
    logic [7:0] lba_mid;
    logic [7:0] lba_high;
    logic [7:0] device;
    logic [7:0] command;
  } taskfile_s;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] error;
    logic [7:0] lba_mid;
    logic [7:0] lba_high;
    logic [7:0] device;
  } completion_s;

  localparam logic [7:0] OP_HEALTH = 8'hB0;
  localparam logic [7:0] SUB_RD_LOG = 8'hD5;
  localparam logic [7:0] SUB_WR_LOG = 8'hD6;
  localparam logic [7:0] SUB_ENABLE = 8'hD8;
  localparam logic [7:0] SUB_DISABLE = 8'hD9;
  localparam logic [7:0] SUB_STATUS = 8'hDA;
  localparam logic [7:0] SIG_MID = 8'h4F;
  localparam logic [7:0] SIG_HIGH = 8'hC2;
  localparam logic [7:0] BAD_MID = 8'hF4;
  localparam logic [7:0] BAD_HIGH = 8'h2C;
  localparam logic [7:0] DEV_IN = 8'hA0;
  localparam logic [7:0] DEV_OUT = 8'hE0;
  localparam logic [7:0] STAT_OK = 8'h50;
  localparam logic [7:0] STAT_ERR = 8'h51;
  localparam logic [7:0] ERR_ABORT = 8'h04;
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] LOG_TUNNEL_CMD = 8'hE0;
  localparam logic [7:0] LOG_TUNNEL_DATA = 8'hE1;
  localparam int SPARE_W_DEF = 16;
  localparam int SPARE_LIMIT_DEF = 3;
endpackage : health_pkg

// ==== verilog/health_signature.sv ====
// spare-block threshold check, returns the status signature pair
// assumes the count is a settled level from the block accounting
`timescale 1ns/1ps
`default_nettype none
module health_signature
#(
  parameter int SPARE_W = health_pkg::SPARE_W_DEF,
  parameter int SPARE_LIMIT = health_pkg::SPARE_LIMIT_DEF
)
(
  input wire logic [SPARE_W-1:0] spare_count, // spare blocks left
  output logic [7:0] sig_mid, // address-mid answer
  output logic [7:0] sig_high, // address-high answer
  output logic exceeded // threshold crossed
);
  import health_pkg::*;

  assign exceeded = (spare_count <= SPARE_W'(SPARE_LIMIT));
  assign sig_mid = exceeded ? BAD_MID : SIG_MID;
  assign sig_high = exceeded ? BAD_HIGH : SIG_HIGH;
endmodule : health_signature
`default_nettype wire

// ==== verilog/health_cmd_ctrl.sv ====
// health-monitoring enable/disable/status sub-command handler
// assumes commands arrive one at a time as parsed register images and
// a nonvolatile bit outside holds the on/off state across power cycles
// Functional notes
// - enable sub-command turns monitoring fully on
// - on/off state kept in nonvolatile storage
// - repeated enable changes nothing
// - disable sub-command turns all monitoring off
// - while off, abort all health sub-commands but enable/tunnel
// - while off, enable and tunnel still processed
// - status answer carried in mid/high fields
// - spares above three: 4F/C2
// - spares three or fewer: F4/2C
`timescale 1ns/1ps
`default_nettype none
module health_cmd_ctrl
#(
  parameter int SPARE_W = health_pkg::SPARE_W_DEF,
  parameter int SPARE_LIMIT = health_pkg::SPARE_LIMIT_DEF
)
(
  input wire logic ref_clk, // 200 MHz device clock
  input wire logic nrst, // async reset, active low
  input wire logic ce, // clock enable, freezes state when low
  input wire logic cmd_valid, // command image present
  input wire health_pkg::taskfile_s cmd, // command register image
  output logic cmd_ready, // handler can take a command
  input wire logic [SPARE_W-1:0] spare_count, // spare-block count
  input wire logic nv_enabled, // stored on/off state
  output logic nv_wr_en, // pulse: store new state
  output logic nv_wr_data, // state to store
  output logic fwd_valid, // pulse: command for other handlers
  output health_pkg::taskfile_s fwd, // forwarded command image
  output logic resp_valid, // pulse: completion ready
  output health_pkg::completion_s resp, // completion register image
  output logic smart_on // monitoring enabled
);
  import health_pkg::*;

  typedef enum logic [0:0] {
    ST_LOAD = 1'b0,
    ST_RUN = 1'b1
  } ctl_state_e;

  ctl_state_e state_reg;
  logic enabled_reg;
  logic take;
  logic is_ours;
  logic sig_ok;
  logic is_tunnel;
  logic do_abort;
  logic do_fwd;
  logic do_enable;
  logic do_disable;
  logic do_status;
  logic [7:0] sig_mid;
  logic [7:0] sig_high;
  logic sig_exceeded;

  health_signature #(
    .SPARE_W(SPARE_W),
    .SPARE_LIMIT(SPARE_LIMIT)
  ) u_sig (
    .spare_count(spare_count),
    .sig_mid(sig_mid),
    .sig_high(sig_high),
    .exceeded(sig_exceeded)
  );

  assign cmd_ready = (state_reg == ST_RUN);
  assign take = cmd_valid & cmd_ready & ce;
  assign smart_on = enabled_reg;

  // decode of one command image
  always_comb
  begin
    is_ours = (cmd.command == OP_HEALTH);
    sig_ok = (cmd.lba_mid == SIG_MID) && (cmd.lba_high == SIG_HIGH) &&
      (cmd.device == DEV_IN);
    is_tunnel = ((cmd.feature == SUB_RD_LOG) ||
      (cmd.feature == SUB_WR_LOG)) &&
      ((cmd.lba_low == LOG_TUNNEL_CMD) || (cmd.lba_low == LOG_TUNNEL_DATA));
    do_enable = 1'b0;
    do_disable = 1'b0;
    do_status = 1'b0;
    do_fwd = 1'b0;
    do_abort = 1'b0;
    if (!is_ours)
    begin
      do_fwd = 1'b1;
    end
    else if (!sig_ok)
    begin
      do_abort = 1'b1;
    end
    else
    begin
      case (cmd.feature)
        SUB_ENABLE: do_enable = 1'b1;
        SUB_DISABLE:
        begin
          do_disable = enabled_reg;
          do_abort = !enabled_reg;
        end
        SUB_STATUS:
        begin
          do_status = enabled_reg;
          do_abort = !enabled_reg;
        end
        default:
        begin
          do_fwd = enabled_reg || is_tunnel;
          do_abort = !(enabled_reg || is_tunnel);
        end
      endcase
    end
  end

  // stored state is copied in once after reset release; the flop itself
  // resets to a constant and the nonvolatile copy is the true owner
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      state_reg <= ST_LOAD;
    else if (ce)
    begin
      case (state_reg)
        ST_LOAD: state_reg <= ST_RUN;
        ST_RUN: state_reg <= ST_RUN;
        default: state_reg <= ST_LOAD;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      enabled_reg <= 1'b0;
    else if (ce)
    begin
      if (state_reg == ST_LOAD)
        enabled_reg <= nv_enabled;
      else if (take && do_enable)
        enabled_reg <= 1'b1;
      else if (take && do_disable)
        enabled_reg <= 1'b0;
    end
  end

  // write the nonvolatile copy only on a real change, so a repeated
  // enable wears nothing and touches no collected data
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      nv_wr_en <= 1'b0;
      nv_wr_data <= 1'b0;
    end
    else if (ce)
    begin
      nv_wr_en <= take && ((do_enable && !enabled_reg) || do_disable);
      if (take && do_enable)
        nv_wr_data <= 1'b1;
      else if (take && do_disable)
        nv_wr_data <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      fwd_valid <= 1'b0;
      fwd <= '0;
    end
    else if (ce)
    begin
      fwd_valid <= take && do_fwd;
      if (take && do_fwd)
        fwd <= cmd;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      resp_valid <= 1'b0;
      resp <= '0;
    end
    else if (ce)
    begin
      resp_valid <= take && !do_fwd;
      if (take && !do_fwd)
      begin
        resp.device <= DEV_OUT;
        resp.status <= do_abort ? STAT_ERR : STAT_OK;
        resp.error <= do_abort ? ERR_ABORT : ERR_NONE;
        resp.lba_mid <= do_status ? sig_mid : 8'h00;
        resp.lba_high <= do_status ? sig_high : 8'h00;
      end
    end
  end

  sequence s_take_status;
    take && do_status;
  endsequence

  sequence s_take_off_disable;
    take && is_ours && sig_ok && (cmd.feature == SUB_DISABLE) &&
      !enabled_reg;
  endsequence

  chk_enable_sets_on: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    take && do_enable |=> smart_on && resp_valid && resp.status == STAT_OK)
    else $error("enable did not turn monitoring on");

  // judged one edge after the load, so the release edge itself never counts
  chk_load_nv_state: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    state_reg == ST_RUN && $past(state_reg) == ST_LOAD |->
      smart_on == $past(nv_enabled))
    else $error("stored state not restored");

  chk_enable_idem: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    take && do_enable && enabled_reg |=> !nv_wr_en && smart_on)
    else $error("repeated enable changed state");

  chk_disable_clears: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    take && do_disable |=> !smart_on && nv_wr_en && !nv_wr_data)
    else $error("disable did not turn monitoring off");

  chk_off_abort: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    s_take_off_disable |=> resp_valid && resp.status == STAT_ERR &&
      resp.error == ERR_ABORT)
    else $error("disable while off not aborted");

  chk_tunnel_pass: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    take && is_ours && sig_ok && is_tunnel |=> fwd_valid && !resp_valid)
    else $error("tunnel command not forwarded");

  chk_status_good: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    s_take_status ##0 (spare_count > SPARE_W'(SPARE_LIMIT)) |=>
      resp.lba_mid == SIG_MID && resp.lba_high == SIG_HIGH)
    else $error("healthy status signature wrong");

  chk_status_bad: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    s_take_status ##0 (spare_count <= SPARE_W'(SPARE_LIMIT)) |=>
      resp.lba_mid == BAD_MID && resp.lba_high == BAD_HIGH)
    else $error("threshold signature wrong");

  chk_bad_signature: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    take && is_ours && !sig_ok |=> resp_valid && resp.status == STAT_ERR)
    else $error("missing signature not aborted");

  // a low ce stretches the pulse, so a frozen edge also explains it
  chk_ok_completion: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    resp_valid && resp.status == STAT_OK |-> resp.device == DEV_OUT &&
      $past(take || !ce) && !fwd_valid)
    else $error("completion fields wrong");
endmodule : health_cmd_ctrl
`default_nettype wire

// ==== tb/nv_bit_model.sv ====
// stand-in for the nonvolatile on/off bit beside the handler
// assumes single-cycle write pulses; the value outlives handler resets
`timescale 1ns/1ps
`default_nettype none
module nv_bit_model
(
  input wire logic ref_clk, // device clock
  input wire logic wr_en, // store pulse
  input wire logic wr_data, // value to store
  output logic stored // kept on/off value
);
  // no reset input: a power cycle or reset must not lose the state
  initial stored = 1'b0;
  always @(posedge ref_clk)
  begin
    if (wr_en)
      stored <= wr_data;
  end
endmodule : nv_bit_model
`default_nettype wire

// ==== tb/test_smart_enable_status_cmds.sv ====
// self-checking bench for the health-monitoring command handler
// assumes ce held high; nonvolatile bit modelled by nv_bit_model
`timescale 1ns/1ps
`default_nettype none
module test_smart_enable_status_cmds;
  import health_pkg::*;
  logic ref_clk, nrst, ce, cmd_valid, cmd_ready, nv_enabled, nv_wr_en;
  logic nv_wr_data, fwd_valid, resp_valid, smart_on;
  logic [15:0] spare_count;
  taskfile_s cmd, fwd;
  completion_s resp;
  int num_errors = 0;
  int tests_run = 0;

  health_cmd_ctrl uut (.ref_clk(ref_clk), .nrst(nrst), .ce(ce),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
    .spare_count(spare_count), .nv_enabled(nv_enabled),
    .nv_wr_en(nv_wr_en), .nv_wr_data(nv_wr_data),
    .fwd_valid(fwd_valid), .fwd(fwd), .resp_valid(resp_valid),
    .resp(resp), .smart_on(smart_on));
  nv_bit_model nv (.ref_clk(ref_clk), .wr_en(nv_wr_en),
    .wr_data(nv_wr_data), .stored(nv_enabled));

  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic cmp(input string what, input logic [55:0] exp,
                     input logic [55:0] got);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask : cmp

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict

  // reset, then wait bounded for the stored state to load
  task automatic do_reset;
    int n;
    @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 20)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    cmp("ready", 1, cmd_ready);
  endtask : do_reset

  // one command image, held until the taking edge, outputs seen after
  task automatic send(input logic [7:0] feat, low, mid, high, dev, op);
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd <= {feat, 8'h00, low, mid, high, dev, op};
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    #1;
  endtask : send

  task automatic smart(input logic [7:0] feat);
    send(feat, 8'h00, SIG_MID, SIG_HIGH, DEV_IN, OP_HEALTH);
  endtask : smart

  task automatic want(input logic [7:0] st, er, mid, high);
    cmp("resp_valid", 1, resp_valid);
    cmp("status", st, resp.status);
    cmp("error", er, resp.error);
    cmp("mid", mid, resp.lba_mid);
    cmp("high", high, resp.lba_high);
    if (st == STAT_OK)
      cmp("device", DEV_OUT, resp.device);
  endtask : want

  task automatic t_enable;
    smart(SUB_ENABLE);
    want(STAT_OK, ERR_NONE, 8'h00, 8'h00);
    cmp("on", 1, smart_on);
    cmp("nv_store", 1, nv_wr_en & nv_wr_data);
    smart(SUB_ENABLE);
    want(STAT_OK, ERR_NONE, 8'h00, 8'h00);
    cmp("nv_store", 0, nv_wr_en);
    cmp("on", 1, smart_on);
  endtask : t_enable

  // boundary of the spare-block threshold on both sides
  task automatic t_status;
    logic [15:0] s [4] = '{16'h0000, 16'h0003, 16'h0004, 16'hFFFF};
    for (int i = 0; i < 4; i++)
    begin
      @(posedge ref_clk);
      spare_count <= s[i];
      smart(SUB_STATUS);
      if (s[i] > 3)
        want(STAT_OK, ERR_NONE, 8'h4F, 8'hC2);
      else
        want(STAT_OK, ERR_NONE, 8'hF4, 8'h2C);
    end
  endtask : t_status

  task automatic t_bad_sig;
    send(SUB_STATUS, 8'h00, 8'h4E, SIG_HIGH, DEV_IN, OP_HEALTH);
    want(STAT_ERR, ERR_ABORT, 8'h00, 8'h00);
    send(SUB_STATUS, 8'h00, SIG_MID, 8'hC3, DEV_IN, OP_HEALTH);
    want(STAT_ERR, ERR_ABORT, 8'h00, 8'h00);
    send(SUB_ENABLE, 8'h00, SIG_MID, SIG_HIGH, 8'hE0, OP_HEALTH);
    want(STAT_ERR, ERR_ABORT, 8'h00, 8'h00);
    send(8'h00, 8'h00, 8'h00, 8'h00, 8'hE0, 8'h25);
    cmp("fwd_valid", 1, fwd_valid);
    cmp("resp_valid", 0, resp_valid);
    cmp("fwd", 56'h0000000000E025, fwd);
    // other sub-commands pass on while monitoring is on
    smart(8'hD4);
    cmp("fwd_valid", 1, fwd_valid);
    cmp("resp_valid", 0, resp_valid);
  endtask : t_bad_sig

  task automatic t_disable;
    smart(SUB_DISABLE);
    want(STAT_OK, ERR_NONE, 8'h00, 8'h00);
    cmp("on", 0, smart_on);
    cmp("nv_store", 1, nv_wr_en & ~nv_wr_data);
    smart(SUB_DISABLE);
    want(STAT_ERR, ERR_ABORT, 8'h00, 8'h00);
    smart(SUB_STATUS);
    want(STAT_ERR, ERR_ABORT, 8'h00, 8'h00);
    smart(8'hD4);
    want(STAT_ERR, ERR_ABORT, 8'h00, 8'h00);
    send(SUB_RD_LOG, LOG_TUNNEL_CMD, SIG_MID, SIG_HIGH, DEV_IN,
      OP_HEALTH);
    cmp("fwd_valid", 1, fwd_valid);
    cmp("resp_valid", 0, resp_valid);
    send(SUB_WR_LOG, LOG_TUNNEL_DATA, SIG_MID, SIG_HIGH, DEV_IN,
      OP_HEALTH);
    cmp("fwd_valid", 1, fwd_valid);
  endtask : t_disable

  // state must come back from the stored bit after each reset
  task automatic t_persist;
    do_reset;
    cmp("on", 0, smart_on);
    smart(SUB_ENABLE);
    want(STAT_OK, ERR_NONE, 8'h00, 8'h00);
    do_reset;
    cmp("on", 1, smart_on);
  endtask : t_persist

  initial
  begin
    #20000;
    num_errors++;
    give_verdict;
  end

  initial
  begin
    nrst = 1'b0;
    ce = 1'b1;
    cmd_valid = 1'b0;
    cmd = '0;
    spare_count = 16'h0010;
    do_reset;
    t_enable;
    t_status;
    t_bad_sig;
    t_disable;
    t_persist;
    give_verdict;
  end
endmodule : test_smart_enable_status_cmds
`default_nettype wire
